//--- bench/fepc_codec_properties.sv
// Purpose : port level assertions for fepc_codec
// Assumes : parameters handed on by the bind
// Notes   : one clock domain, so default clocking is used
`timescale 1ns/1ps
module fepc_codec_properties #(
  parameter HOLD_CYCLES = 600,
  parameter LINK_CYCLES = 200
) (
  input wire        sys_clk_in,
  input wire        rst_in,
  input wire        bit_en_in,
  input wire        signal_detect_in,
  input wire        link_pulse_in,
  input wire        descr_bypass_in,
  input wire        tx_nib_req_out,
  input wire        mlt_pos_out,
  input wire        mlt_neg_out,
  input wire        rx_dv_out,
  input wire        link_up_out,
  input wire        descr_sync_out,
  input wire [15:0] false_carrier_counter_out
);
  default clocking cb @(posedge sys_clk_in); endclocking
  default disable iff (rst_in);
  reg        seen;
  reg        last_pos;
  reg [15:0] ok_cnt;
  // ------------------------------------------------------------
  // helper logic
  // ------------------------------------------------------------
  always @(posedge sys_clk_in) begin
    if (rst_in) begin
      seen <= 1'b0;
      last_pos <= 1'b0;
      ok_cnt <= 16'h0000;
    end else begin
      if ($rose(mlt_pos_out) || $rose(mlt_neg_out)) begin
        seen <= 1'b1;
        last_pos <= mlt_pos_out;
      end
      // saturate so a long run never wraps back below the link figure
      if (!signal_detect_in || link_pulse_in)
        ok_cnt <= 16'h0000;
      else if (ok_cnt != 16'hFFFF)
        ok_cnt <= ok_cnt + 16'h0001;
    end
  end
  sequence s_req_gap;
    !tx_nib_req_out [*4];
  endsequence
  // ------------------------------------------------------------
  // assertions
  // ------------------------------------------------------------
  a_mlt_exclusive: assert property (!(mlt_pos_out && mlt_neg_out)) else $error("both mlt streams high");
  a_mlt_alternate: assert property (seen && ($rose(mlt_pos_out) || $rose(mlt_neg_out)) |-> mlt_pos_out != last_pos)
    else $error("mlt ones did not alternate");
  a_mlt_bit_step: assert property (($changed(mlt_pos_out) || $changed(mlt_neg_out)) |-> $past(bit_en_in))
    else $error("mlt output moved without a bit enable");
  a_req_group_gap: assert property (tx_nib_req_out |=> s_req_gap) else $error("nibble requests too close");
  a_tx_needs_link: assert property (!link_up_out |-> !tx_nib_req_out) else $error("nibble taken while link down");
  a_link_min_time: assert property ($rose(link_up_out) |-> ok_cnt >= LINK_CYCLES - 2)
    else $error("link up too early");
  a_link_max_time: assert property (ok_cnt == LINK_CYCLES + 4 |-> link_up_out) else $error("link up late");
  a_dv_single: assert property (rx_dv_out |=> !rx_dv_out) else $error("rx_dv longer than one cycle");
  a_dv_link_up: assert property (rx_dv_out |-> link_up_out) else $error("receive nibble while link down");
  a_dv_when_sync: assert property (rx_dv_out && !descr_bypass_in |-> descr_sync_out)
    else $error("receive nibble without descrambler lock");
  a_fc_step_one: assert property ($changed(false_carrier_counter_out) |->
    false_carrier_counter_out == $past(false_carrier_counter_out) + 16'h0001) else $error("false carrier count step");
endmodule // fepc_codec_properties

bind fepc_codec fepc_codec_properties #(.HOLD_CYCLES(HOLD_CYCLES), .LINK_CYCLES(LINK_CYCLES)) fepc_codec_properties_inst (
  .sys_clk_in(sys_clk_in), .rst_in(rst_in), .bit_en_in(bit_en_in), .signal_detect_in(signal_detect_in),
  .link_pulse_in(link_pulse_in), .descr_bypass_in(descr_bypass_in), .tx_nib_req_out(tx_nib_req_out),
  .mlt_pos_out(mlt_pos_out), .mlt_neg_out(mlt_neg_out), .rx_dv_out(rx_dv_out), .link_up_out(link_up_out),
  .descr_sync_out(descr_sync_out), .false_carrier_counter_out(false_carrier_counter_out));

//--- bench/fepc_codec_tb.sv
// Purpose : self-checking bench for fepc_codec
// Assumes : bit enable every second clock, short hold and link counts
// Notes   : transmit output is looped back to the receiver via nrzi rebuild
`timescale 1ns/1ps
module fepc_codec_tb;
  localparam HOLD = 600;
  localparam LINK = 200;
  reg         sys_clk = 1'b0;
  reg         rst = 1'b1;
  reg         bit_en = 1'b0;
  reg         sd = 1'b0;
  reg         lpulse = 1'b0;
  reg         bypass = 1'b0;
  reg         loop = 1'b1;
  reg         lb_lvl = 1'b0;
  reg         drv_lvl = 1'b0;
  reg         er_seen = 1'b0;
  reg         fc_seen = 1'b0;
  reg  [15:0] fc;
  integer     failures = 0;
  integer     num_checks = 0;
  wire        tx_en, req, pos, neg, dv, er, crs, link, sync;
  wire [3:0]  txd, rxd;
  wire [15:0] fcc;
  fepc_codec #(.HOLD_CYCLES(HOLD), .LINK_CYCLES(LINK)) fepc_codec_inst (
    .sys_clk_in(sys_clk), .rst_in(rst), .bit_en_in(bit_en), .phy_address_straps_in(5'h13),
    .descr_bypass_in(bypass), .tx_en_in(tx_en), .txd_in(txd), .tx_nib_req_out(req), .mlt_pos_out(pos),
    .mlt_neg_out(neg), .rx_nrzi_in(loop ? lb_lvl : drv_lvl), .signal_detect_in(sd), .link_pulse_in(lpulse),
    .rxd_out(rxd), .rx_dv_out(dv), .rx_er_out(er), .rx_crs_out(crs), .link_up_out(link),
    .descr_sync_out(sync), .false_carrier_counter_out(fcc));
  fepc_mac_model fepc_mac_model_inst (.sys_clk_in(sys_clk), .tx_nib_req_in(req), .rx_dv_in(dv), .rxd_in(rxd),
    .tx_en_out(tx_en), .txd_out(txd));
  always #2.5 sys_clk = ~sys_clk;
  always @(posedge sys_clk) bit_en <= #1 ~bit_en;
  // a one on either mlt stream is a line transition, rebuilt here as nrzi
  always @(posedge sys_clk) if (bit_en && (pos || neg)) lb_lvl <= #1 ~lb_lvl;
  always @(posedge sys_clk) begin
    if (er === 1'b1) er_seen <= 1'b1;
    if (er === 1'b1 && rxd === 4'hE) fc_seen <= 1'b1;
  end
  // ------------------------------------------------------------
  // shared tasks
  // ------------------------------------------------------------
  task check(input bit ok, input string msg);
    num_checks = num_checks + 1;
    if (!ok) begin
      failures = failures + 1;
      $display("ERROR %0t %s", $time, msg);
    end
  endtask
  task send_cg(input [4:0] cg);
    integer i;
    for (i = 4; i >= 0; i--) begin
      do @(posedge sys_clk); while (bit_en !== 1'b1);
      #1 drv_lvl = drv_lvl ^ cg[i];
    end
  endtask
  task finish_test;
    $display("checks %0d failures %0d", num_checks, failures);
    if (failures == 0 && num_checks > 0) $display("TB: PASS");
    else $display("TB: FAIL");
    $finish;
  endtask
  // ------------------------------------------------------------
  // scenarios
  // ------------------------------------------------------------
  task t_link;
    integer n;
    sd = 1'b1;
    lpulse = 1'b1;
    repeat (LINK + 100) @(posedge sys_clk);
    check(link === 1'b0, "link came up on link pulses");
    #1 lpulse = 1'b0;
    n = 0;
    while (link !== 1'b1 && n < 2000) begin @(posedge sys_clk); n = n + 1; end
    check(link === 1'b1 && n >= LINK - 2, "link up timing");
  endtask
  task t_frame(input integer len);
    integer i, k;
    logic [3:0] exp[$];
    k = 0;
    while (sync !== 1'b1 && k < 3000) begin @(posedge sys_clk); k = k + 1; end
    check(sync === 1'b1, "descrambler never locked");
    fepc_mac_model_inst.rx_q.delete();
    exp = {4'h5};
    @(posedge sys_clk);
    #2 er_seen = 1'b0;
    for (i = 0; i < len; i++) begin
      exp.push_back(4'(i * 7 + 3));
      fepc_mac_model_inst.load(4'(i * 7 + 3));
    end
    k = 0;
    while ((fepc_mac_model_inst.rx_q.size() < len + 1 || crs !== 1'b0) && k < 5000) begin
      @(posedge sys_clk);
      k = k + 1;
    end
    check(fepc_mac_model_inst.rx_q.size() == len + 1 && crs === 1'b0, "frame length or end");
    for (i = 0; i <= len && i < fepc_mac_model_inst.rx_q.size(); i++)
      check(fepc_mac_model_inst.rx_q[i] === exp[i], "looped nibble mismatch");
    check(er_seen === 1'b0 && tx_en === 1'b0, "error in clean frame");
    // idle fill must keep the hold timer restarted well past its span
    repeat (2 * HOLD) @(posedge sys_clk);
    check(sync === 1'b1 && crs === 1'b0, "idle fill lost lock");
    check(fepc_mac_model_inst.rx_q.size() == len + 1, "nibbles during idle");
  endtask
  task t_hold;
    integer k;
    #1 loop = 1'b0;
    k = 0;
    while (sync !== 1'b0 && k < HOLD + 1000) begin @(posedge sys_clk); k = k + 1; end
    check(sync === 1'b0, "lock kept without idle");
  endtask
  task t_errors;
    bypass = 1'b1;
    repeat (20) send_cg(5'h1F);
    fc = fcc;
    er_seen = 1'b0;
    fc_seen = 1'b0;
    send_cg(5'h14);
    send_cg(5'h14);
    repeat (4) send_cg(5'h1F);
    repeat (2) send_cg(5'h1F); // a silent line reads as zeros, so keep idling
    check(fc_seen === 1'b1, "no false carrier report");
    check(fcc === fc + 16'h0001, "false carrier count");
    check(er === 1'b0 && crs === 1'b0, "false carrier not ended by idles");
    fepc_mac_model_inst.rx_q.delete();
    er_seen = 1'b0;
    send_cg(5'h18);
    send_cg(5'h11);
    send_cg(5'h15);
    send_cg(5'h18);
    send_cg(5'h0D);
    send_cg(5'h07);
    repeat (4) send_cg(5'h1F);
    repeat (2) send_cg(5'h1F);
    check(er_seen === 1'b1, "control group in data not flagged");
    check(fepc_mac_model_inst.rx_q.size() > 1, "bypass frame lost");
    if (fepc_mac_model_inst.rx_q.size() > 1)
      check(fepc_mac_model_inst.rx_q[0] === 4'h5 && fepc_mac_model_inst.rx_q[1] === 4'h3, "bypass nibbles");
    check(crs === 1'b0, "carrier after end pair");
  endtask
  initial begin
    repeat (8) @(posedge sys_clk);
    #1 rst = 1'b0;
    t_link();
    t_frame(1);
    t_frame(16);
    t_hold();
    t_errors();
    finish_test();
  end
  initial begin
    #300000;
    failures = failures + 1;
    finish_test();
  end
endmodule // fepc_codec_tb

//--- bench/fepc_mac_model.sv
// Purpose : mac side model: feeds transmit nibbles, logs receive nibbles
// Assumes : tx_nib_req is a one-cycle combinational pulse
// Notes   : txd toggles while idle so a stale nibble is never mistaken for data
`timescale 1ns/1ps
module fepc_mac_model (
  input  wire       sys_clk_in,
  input  wire       tx_nib_req_in,
  input  wire       rx_dv_in,
  input  wire [3:0] rxd_in,
  output reg        tx_en_out,
  output reg  [3:0] txd_out
);
  logic [3:0] tx_q[$];
  logic [3:0] rx_q[$];
  initial begin
    tx_en_out = 1'b0;
    txd_out = 4'h0;
  end
  task load(input logic [3:0] nib);
    tx_q.push_back(nib);
  endtask
  always @(posedge sys_clk_in) begin
    if (tx_nib_req_in === 1'b1 && tx_q.size() > 0)
      void'(tx_q.pop_front());
    if (rx_dv_in === 1'b1)
      rx_q.push_back(rxd_in);
    #1;
    tx_en_out = tx_q.size() > 0;
    txd_out = (tx_q.size() > 0) ? tx_q[0] : ~txd_out;
  end
endmodule // fepc_mac_model

//--- hdl/fepc_codec.v
// Purpose : 100 Mb/s pcs codec: 4B/5B, scrambling, nrzi, mlt-3 and receive recovery
// Assumes : bit_en_in pulses once per line bit; nibble strobes are one-cycle pulses
// Notes   : the mac feeds one nibble per tx_nib_req_out; receive nibbles pulse rx_dv_out
`timescale 1ns/1ps
`include "fepc_consts.vh"
module fepc_codec #(
  parameter HOLD_CYCLES = `FEPC_HOLD_US * `FEPC_CLK_MHZ,
  parameter LINK_CYCLES = `FEPC_LINK_US * `FEPC_CLK_MHZ
) (
  input  wire       sys_clk_in,
  input  wire       rst_in,
  input  wire       bit_en_in,
  input  wire [4:0] phy_address_straps_in,
  input  wire       descr_bypass_in,
  input  wire       tx_en_in,
  input  wire [3:0] txd_in,
  output wire       tx_nib_req_out,
  output reg        mlt_pos_out,
  output reg        mlt_neg_out,
  input  wire       rx_nrzi_in,
  input  wire       signal_detect_in,
  input  wire       link_pulse_in,
  output reg  [3:0] rxd_out,
  output reg        rx_dv_out,
  output reg        rx_er_out,
  output reg        rx_crs_out,
  output reg        link_up_out,
  output reg        descr_sync_out,
  output reg [15:0] false_carrier_counter_out
);
  // -------------------------------------------------
  // local states
  // -------------------------------------------------
  localparam TX_IDLE = 3'd0;
  localparam TX_J    = 3'd1;
  localparam TX_K    = 3'd2;
  localparam TX_DATA = 3'd3;
  localparam TX_T    = 3'd4;
  localparam TX_R    = 3'd5;
  localparam RX_IDLE  = 2'd0;
  localparam RX_DATA  = 2'd1;
  localparam RX_FALSE = 2'd2;

  // -------------------------------------------------
  // link monitor
  // -------------------------------------------------
  reg [31:0] link_cnt;
  wire       sd_ok;
  // link pulses are energy bursts of 10BASE-T/autoneg, never 100M signal
  assign sd_ok = signal_detect_in & ~link_pulse_in;
  always @(posedge sys_clk_in) begin
    if (rst_in) begin
      link_cnt    <= 32'h0000_0000;
      link_up_out <= 1'b0;
    end else if (!sd_ok) begin
      link_cnt    <= 32'h0000_0000;
      link_up_out <= 1'b0;
    end else if (link_cnt >= LINK_CYCLES - 1) begin
      link_up_out <= 1'b1;
    end else begin
      link_cnt <= link_cnt + 32'h0000_0001;
    end
  end

  // -------------------------------------------------
  // transmit: code-group sequencing
  // -------------------------------------------------
  reg  [2:0] tx_st;
  reg  [4:0] tx_sh;
  reg  [2:0] tx_bit;
  reg        tx_pre_skip;
  wire [4:0] enc_cg;
  wire       cg_bound;
  reg  [2:0] next_tx_st;
  reg  [4:0] next_cg;
  reg        seeded;
  wire       tx_key;
  wire       rx_key;
  wire [10:0] rx_lfsr_st;
  wire [10:0] tx_lfsr_st;
  wire [4:0] rx_cg_w;
  wire [3:0] dec_nib;
  wire       dec_ctrl;
  wire       dec_bad;

  assign cg_bound = bit_en_in & (tx_bit == 3'd4);
  // nibble requested only in k and data; j/k go out before the first mac nibble, which is sent as data
  assign tx_nib_req_out = cg_bound & link_up_out & tx_en_in &
                          ((tx_st == TX_DATA) | (tx_st == TX_K));

  always @* begin
    next_tx_st = tx_st;
    next_cg    = `FEPC_CG_IDLE;
    case (tx_st)
      TX_IDLE: begin
        if (tx_en_in && link_up_out) begin
          next_tx_st = TX_J;
          next_cg    = `FEPC_CG_J;
        end
      end
      TX_J: begin
        next_tx_st = TX_K;
        next_cg    = `FEPC_CG_K;
      end
      TX_K, TX_DATA: begin
        if (tx_en_in) begin
          next_tx_st = TX_DATA;
          next_cg    = enc_cg;
        end else begin
          next_tx_st = TX_T;
          next_cg    = `FEPC_CG_T;
        end
      end
      TX_T: begin
        next_tx_st = TX_R;
        next_cg    = `FEPC_CG_R;
      end
      TX_R: begin
        next_tx_st = TX_IDLE;
      end
      default: next_tx_st = TX_IDLE;
    endcase
  end

  fepc_tables u_tab (
    .enc_nib_in   (txd_in),
    .enc_cg_out   (enc_cg),
    .dec_cg_in    (rx_cg_w),
    .dec_nib_out  (dec_nib),
    .dec_ctrl_out (dec_ctrl),
    .dec_bad_out  (dec_bad)
  );

  // tx_pre_skip follows the j state but nothing reads it; every mac nibble is sent after j/k
  always @(posedge sys_clk_in) begin
    if (rst_in) begin
      tx_st       <= TX_IDLE;
      tx_sh       <= `FEPC_CG_IDLE;
      tx_bit      <= 3'd0;
      tx_pre_skip <= 1'b0;
    end else if (bit_en_in) begin
      if (tx_bit == 3'd4) begin
        tx_bit <= 3'd0;
        tx_st  <= next_tx_st;
        tx_sh  <= next_cg;
      end else begin
        tx_bit <= tx_bit + 3'd1;
        tx_sh  <= {tx_sh[3:0], 1'b0};
      end
      tx_pre_skip <= (tx_st == TX_J);
    end
  end

  // -------------------------------------------------
  // transmit: scrambler, nrzi, mlt-3
  // -------------------------------------------------
  always @(posedge sys_clk_in) begin
    if (rst_in) begin
      seeded <= 1'b0;
    end else begin
      seeded <= 1'b1;
    end
  end

  fepc_lfsr u_tx_lfsr (
    .sys_clk_in (sys_clk_in),
    .rst_in     (rst_in),
    .load_in    (~seeded),
    .seed_in    ({`FEPC_SEED_PAD, phy_address_straps_in}),
    .step_in    (bit_en_in),
    .key_out    (tx_key),
    .state_out  (tx_lfsr_st)
  );

  reg  nrzi;
  reg  mlt_phase;
  wire scr_bit;
  assign scr_bit = tx_sh[4] ^ tx_key;

  // both outputs low marks a zero bit with no line transition; there is no binary output path
  always @(posedge sys_clk_in) begin
    if (rst_in) begin
      nrzi        <= 1'b0;
      mlt_phase   <= 1'b0;
      mlt_pos_out <= 1'b0;
      mlt_neg_out <= 1'b0;
    end else if (bit_en_in) begin
      mlt_pos_out <= 1'b0;
      mlt_neg_out <= 1'b0;
      if (scr_bit) begin
        nrzi      <= ~nrzi;
        mlt_phase <= ~mlt_phase;
        mlt_pos_out <= ~mlt_phase;
        mlt_neg_out <= mlt_phase;
      end
    end
  end

  // -------------------------------------------------
  // receive: nrzi decode and descrambler
  // -------------------------------------------------
  reg        rx_prev;
  wire       rx_nrz;
  wire       rx_ud;
  reg  [9:0] rx_win;
  reg  [3:0] idle_run;
  reg  [5:0] idle_bits;
  reg [31:0] hold_cnt;
  reg        hold_exp;
  assign rx_nrz = rx_nrzi_in ^ rx_prev;

  // self-synchronising load: feed inverted scrambled bits into key state until locked
  fepc_lfsr u_rx_lfsr (
    .sys_clk_in (sys_clk_in),
    .rst_in     (rst_in),
    .load_in    (bit_en_in & ~descr_sync_out),
    .seed_in    ({rx_lfsr_st[9:0], ~rx_nrz}),
    .step_in    (bit_en_in),
    .key_out    (rx_key),
    .state_out  (rx_lfsr_st)
  );
  // idle plaintext is all ones, so scrambled bit inverted is the key
  assign rx_ud = descr_bypass_in ? rx_nrz : (rx_nrz ^ rx_key);

  always @(posedge sys_clk_in) begin
    if (rst_in) begin
      rx_prev        <= 1'b0;
      rx_win         <= 10'h0_00;
      idle_run       <= 4'd0;
      idle_bits      <= 6'd0;
      hold_cnt       <= 32'h0000_0000;
      hold_exp       <= 1'b0;
      descr_sync_out <= 1'b0;
    end else begin
      hold_exp <= 1'b0;
      if (descr_sync_out) begin
        if (hold_cnt >= HOLD_CYCLES - 1) begin
          descr_sync_out <= 1'b0;
          hold_exp       <= 1'b1;
          hold_cnt       <= 32'h0000_0000;
        end else begin
          hold_cnt <= hold_cnt + 32'h0000_0001;
        end
      end
      if (bit_en_in) begin
        rx_prev <= rx_nrzi_in;
        rx_win  <= {rx_win[8:0], rx_ud};
        if (!link_up_out) begin
          idle_run  <= 4'd0;
          idle_bits <= 6'd0;
          descr_sync_out <= 1'b0;
        end else if (!descr_sync_out) begin
          // count ones; every fifth is one idle group
          if (rx_ud) begin
            idle_bits <= idle_bits + 6'd1;
            if (idle_bits >= 6'd4 && (idle_bits - 6'd4) % 6'd5 == 6'd0) begin
              idle_run <= idle_run + 4'd1;
            end
          end else begin
            idle_bits <= 6'd0;
            idle_run  <= 4'd0;
          end
          if (idle_run >= `FEPC_SYNC_IDLES) begin
            descr_sync_out <= 1'b1;
            hold_cnt       <= 32'h0000_0000;
            idle_bits      <= 6'd0;
            idle_run       <= 4'd0;
          end
        end else begin
          if (rx_ud) begin
            if (idle_bits >= `FEPC_IDLE_BITS - 1) begin
              hold_cnt  <= 32'h0000_0000;
              idle_bits <= 6'd0;
            end else begin
              idle_bits <= idle_bits + 6'd1;
            end
          end else begin
            idle_bits <= 6'd0;
          end
        end
      end
    end
  end

  // -------------------------------------------------
  // receive: alignment, decode, framing
  // -------------------------------------------------
  reg  [1:0] rx_st;
  reg  [2:0] rx_phase;
  reg        aligned;
  reg  [4:0] rx_cg;
  reg        rx_cg_vld;
  reg        pend_t;
  reg        pend_i;
  wire       rx_active;
  wire       jk_seen;
  wire       bad_start;
  assign rx_cg_w   = rx_cg;
  assign rx_active = link_up_out & (descr_sync_out | descr_bypass_in);
  assign jk_seen   = ({rx_win[8:0], rx_ud} == {`FEPC_CG_J, `FEPC_CG_K});
  // judged on bits, not groups: before alignment the group boundary is arbitrary,
  // so the first zero after idle is checked once a whole j/k could have followed it
  assign bad_start = bit_en_in & (rx_win[9:7] == 3'b111) & ~rx_win[6] & ~jk_seen;

  always @(posedge sys_clk_in) begin
    if (rst_in) begin
      rx_phase  <= 3'd0;
      aligned   <= 1'b0;
      rx_cg     <= `FEPC_CG_IDLE;
      rx_cg_vld <= 1'b0;
    end else begin
      rx_cg_vld <= 1'b0;
      if (bit_en_in && rx_active) begin
        if (jk_seen && rx_st != RX_DATA) begin
          rx_phase  <= 3'd0;
          aligned   <= 1'b1;
          rx_cg     <= `FEPC_CG_K;
          rx_cg_vld <= 1'b1;
        end else if (rx_phase == 3'd4) begin
          rx_phase  <= 3'd0;
          rx_cg     <= {rx_win[3:0], rx_ud};
          rx_cg_vld <= 1'b1;
        end else begin
          rx_phase <= rx_phase + 3'd1;
        end
      end else if (!rx_active) begin
        aligned <= 1'b0;
      end
    end
  end

  // outputs pulse rx_dv_out for the starting k and each data group other than t, idle or r after t
  always @(posedge sys_clk_in) begin
    if (rst_in) begin
      rx_st      <= RX_IDLE;
      rxd_out    <= 4'h0;
      rx_dv_out  <= 1'b0;
      rx_er_out  <= 1'b0;
      rx_crs_out <= 1'b0;
      pend_t     <= 1'b0;
      pend_i     <= 1'b0;
      false_carrier_counter_out <= 16'h0000;
    end else begin
      rx_dv_out <= 1'b0;
      if (!rx_active) begin
        rx_st      <= RX_IDLE;
        rx_er_out  <= 1'b0;
        rx_crs_out <= 1'b0;
      end else if (bad_start && rx_st == RX_IDLE) begin
        rx_st      <= RX_FALSE;
        rx_crs_out <= 1'b1;
        rx_er_out  <= 1'b1;
        rxd_out    <= `FEPC_NIB_FALSE;
        false_carrier_counter_out <= false_carrier_counter_out + 16'h0001;
      end else if (rx_cg_vld) begin
        pend_i    <= (rx_cg == `FEPC_CG_IDLE);
        pend_t    <= (rx_cg == `FEPC_CG_T);
        case (rx_st)
          RX_IDLE: begin
            rx_er_out <= 1'b0;
            // idle state is also reached through a t/r pair, so j/k here can follow r as well as idle
            if (rx_cg == `FEPC_CG_K && aligned) begin
              rx_st      <= RX_DATA;
              rx_crs_out <= 1'b1;
              rxd_out    <= `FEPC_NIB_PRE;
              rx_dv_out  <= 1'b1;
            end
          end
          RX_DATA: begin
            if ((pend_t && rx_cg == `FEPC_CG_R) || (pend_i && rx_cg == `FEPC_CG_IDLE)) begin
              rx_st      <= RX_IDLE;
              rx_crs_out <= 1'b0;
              rx_er_out  <= 1'b0;
            end else if (rx_cg == `FEPC_CG_T || rx_cg == `FEPC_CG_IDLE) begin
              rx_er_out <= 1'b0;
            end else begin
              rxd_out   <= dec_nib;
              rx_dv_out <= 1'b1;
              rx_er_out <= dec_ctrl | dec_bad;
            end
          end
          RX_FALSE: begin
            rxd_out <= `FEPC_NIB_FALSE;
            if (pend_i && rx_cg == `FEPC_CG_IDLE) begin
              rx_st      <= RX_IDLE;
              rx_er_out  <= 1'b0;
              rx_crs_out <= 1'b0;
            end
          end
          default: rx_st <= RX_IDLE;
        endcase
      end
    end
  end
endmodule // fepc_codec

//--- hdl/fepc_consts.vh
// Purpose : shared constants for the fast ethernet pcs codec
// Assumes : 200 MHz system clock, serial side advanced by a one-cycle bit enable
// Notes   : code-group values are written msb-first as transmitted
`ifndef FEPC_CONSTS_VH
`define FEPC_CONSTS_VH

`define FEPC_CLK_MHZ        200
`define FEPC_LFSR_W         11
`define FEPC_SEED_PAD       6'h2_A
`define FEPC_CG_IDLE        5'h1_F
`define FEPC_CG_J           5'h1_8
`define FEPC_CG_K           5'h1_1
`define FEPC_CG_T           5'h0_D
`define FEPC_CG_R           5'h0_7
`define FEPC_CG_HALT        5'h0_4
`define FEPC_NIB_PRE        4'h5
`define FEPC_NIB_FALSE      4'hE
`define FEPC_SYNC_IDLES     12
`define FEPC_HOLD_US        722
`define FEPC_IDLE_BITS      58
`define FEPC_LINK_US        395

`endif

//--- hdl/fepc_lfsr.v
// Purpose : 11-bit key generator shared by scrambler and descrambler
// Assumes : advances only when step_in is high
// Notes   : load_in wins over step_in
`timescale 1ns/1ps
`include "fepc_consts.vh"
module fepc_lfsr (
  input  wire                    sys_clk_in,
  input  wire                    rst_in,
  input  wire                    load_in,
  input  wire [`FEPC_LFSR_W-1:0] seed_in,
  input  wire                    step_in,
  output wire                    key_out,
  output reg  [`FEPC_LFSR_W-1:0] state_out
);
  // -------------------------------------------------
  // feedback x^11 + x^9 + 1
  // -------------------------------------------------
  wire fb;
  assign fb      = state_out[10] ^ state_out[8];
  assign key_out = fb;

  always @(posedge sys_clk_in) begin
    if (rst_in) begin
      state_out <= 11'h7_FF;
    end else if (load_in) begin
      state_out <= (seed_in == 11'h0_00) ? 11'h7_FF : seed_in;
    end else if (step_in) begin
      state_out <= {state_out[9:0], fb};
    end
  end
endmodule // fepc_lfsr

//--- hdl/fepc_tables.v
// Purpose : 4B/5B code tables
// Assumes : purely combinational
// Notes   : dec_ctrl_out set for idle, j, k, t, r, halt; dec_bad_out for unused codes
`timescale 1ns/1ps
`include "fepc_consts.vh"
module fepc_tables (
  input  wire [3:0] enc_nib_in,
  output reg  [4:0] enc_cg_out,
  input  wire [4:0] dec_cg_in,
  output reg  [3:0] dec_nib_out,
  output reg        dec_ctrl_out,
  output reg        dec_bad_out
);
  // -------------------------------------------------
  // encode
  // -------------------------------------------------
  always @* begin
    case (enc_nib_in)
      4'h0: enc_cg_out = 5'h1_E;
      4'h1: enc_cg_out = 5'h0_9;
      4'h2: enc_cg_out = 5'h1_4;
      4'h3: enc_cg_out = 5'h1_5;
      4'h4: enc_cg_out = 5'h0_A;
      4'h5: enc_cg_out = 5'h0_B;
      4'h6: enc_cg_out = 5'h0_E;
      4'h7: enc_cg_out = 5'h0_F;
      4'h8: enc_cg_out = 5'h1_2;
      4'h9: enc_cg_out = 5'h1_3;
      4'hA: enc_cg_out = 5'h1_6;
      4'hB: enc_cg_out = 5'h1_7;
      4'hC: enc_cg_out = 5'h1_A;
      4'hD: enc_cg_out = 5'h1_B;
      4'hE: enc_cg_out = 5'h1_C;
      default: enc_cg_out = 5'h1_D;
    endcase
  end

  // -------------------------------------------------
  // decode
  // -------------------------------------------------
  always @* begin
    dec_ctrl_out = 1'b0;
    dec_bad_out  = 1'b0;
    case (dec_cg_in)
      5'h1_E: dec_nib_out = 4'h0;
      5'h0_9: dec_nib_out = 4'h1;
      5'h1_4: dec_nib_out = 4'h2;
      5'h1_5: dec_nib_out = 4'h3;
      5'h0_A: dec_nib_out = 4'h4;
      5'h0_B: dec_nib_out = 4'h5;
      5'h0_E: dec_nib_out = 4'h6;
      5'h0_F: dec_nib_out = 4'h7;
      5'h1_2: dec_nib_out = 4'h8;
      5'h1_3: dec_nib_out = 4'h9;
      5'h1_6: dec_nib_out = 4'hA;
      5'h1_7: dec_nib_out = 4'hB;
      5'h1_A: dec_nib_out = 4'hC;
      5'h1_B: dec_nib_out = 4'hD;
      5'h1_C: dec_nib_out = 4'hE;
      5'h1_D: dec_nib_out = 4'hF;
      `FEPC_CG_IDLE, `FEPC_CG_J, `FEPC_CG_K, `FEPC_CG_T, `FEPC_CG_R, `FEPC_CG_HALT: begin
        dec_nib_out  = 4'h0;
        dec_ctrl_out = 1'b1;
      end
      default: begin
        dec_nib_out = 4'h0;
        dec_bad_out = 1'b1;
      end
    endcase
  end
endmodule // fepc_tables
